// ===== rtl/cer_pkg.sv
// cer_pkg: constants, enums and carriers for exception entry and return
// assumes one core clock and a pipeline that offers one instruction slot
//
// Behaviour
// RULE1 - return loads counter from backup counter
// RULE2 - return copies saved flags into live flags
// RULE3 - saved bits undefined after return
// RULE4 - vector table starts at address zero
// RULE5 - sixteen trap vectors, four bytes apart
// RULE6 - break and peripheral vectors, clear mode
// RULE7 - flash reprogramming moves power-on vector
// RULE8 - reserved opcode raises undefined-opcode fault
// RULE9 - faulting opcode has no effect
// RULE10 - undefined opcode beats peripheral interrupt
// RULE11 - entry first saves the live flags
// RULE12 - faults keep mode, clear enable, carry
// RULE13 - faults save the faulting instruction address
// RULE14 - backup bit shows halfword position
// RULE15 - return clears two low address bits
// RULE16 - undefined opcode vectors to 0x20
// RULE17 - misaligned access vectors to 0x30
// RULE18 - vector entry holds jump to handler
// RULE19 - handler pushes backup, status, registers
// RULE20 - handler pops them, then returns
// RULE21 - odd halfword address is misaligned
// RULE22 - unaligned word or lock access misaligned
// RULE23 - misaligned access makes no memory access
// RULE24 - peripheral interrupt needs boundary and enable
// RULE25 - entry order: save, update, capture, vector
// RULE26 - fault wins, interrupt stays pending
package cer_pkg;

  localparam int ADDR_W = 32;
  localparam int OPC_W = 16;
  localparam logic [31:0] VEC_POWER_ON = 32'h0000_0000;
  localparam logic [31:0] VEC_POWER_ON_FLASH = 32'h0080_1000;
  localparam logic [31:0] VEC_SYS_BREAK = 32'h0000_0010;
  localparam logic [31:0] VEC_UNDEF = 32'h0000_0020;
  localparam logic [31:0] VEC_MISALIGN = 32'h0000_0030;
  localparam logic [31:0] VEC_TRAP_BASE = 32'h0000_0040;
  localparam logic [31:0] VEC_PERIPH = 32'h0000_0080;
  localparam logic [31:0] NEXT_INSTR_STEP = 32'h0000_0004;
  localparam logic [1:0] WORD_ALIGNED = 2'h0;
  // halfword position bit, bit 30 in msb-first numbering
  localparam int HALF_POS_BIT = 1;
  localparam int MAJOR_MSB = 15;
  localparam int MAJOR_LSB = 12;
  localparam logic [1:0] BOOT_WAIT = 2'h3;
  localparam logic RESET_FLAG = 1'h0;

  typedef enum logic [2:0]
  {
    CER_MEM_NONE = 3'h0,
    CER_MEM_HALF_S = 3'h1,
    CER_MEM_HALF_U = 3'h2,
    CER_MEM_HALF_W = 3'h3,
    CER_MEM_WORD_R = 3'h4,
    CER_MEM_WORD_W = 3'h5,
    CER_MEM_LOCK_R = 3'h6,
    CER_MEM_UNLOCK_W = 3'h7
  } cer_mem_e;

  typedef enum logic [2:0]
  {
    CER_CAUSE_NONE = 3'h0,
    CER_CAUSE_SYS_BREAK = 3'h1,
    CER_CAUSE_UNDEF = 3'h2,
    CER_CAUSE_MISALIGN = 3'h3,
    CER_CAUSE_TRAP = 3'h4,
    CER_CAUSE_PERIPH = 3'h5,
    CER_CAUSE_POWER_ON = 3'h6
  } cer_cause_e;

  typedef enum logic [2:0]
  {
    CER_IDLE = 3'h0,
    CER_SAVE = 3'h1,
    CER_UPDATE = 3'h3,
    CER_CAPTURE = 3'h2,
    CER_VECTOR = 3'h6,
    CER_BOOT = 3'h7
  } cer_state_e;

  typedef struct packed
  {
    logic valid;
    logic [31:0] instr_addr;
    logic [15:0] opcode;
    cer_mem_e mem_kind;
    logic [1:0] mem_addr_low;
    logic trap;
    logic [3:0] trap_num;
    logic return_from_handler_op;
    logic break_point;
  } cer_slot_s;

  typedef struct packed
  {
    logic saved_stack_mode;
    logic saved_interrupt_enable;
    logic saved_arith_out_flag;
    logic stack_mode_select;
    logic interrupt_enable;
    logic carry_flag;
  } cer_psw_s;

endpackage

// ===== rtl/cer_top.sv
// cer_top: exception entry and return sequencer of the core
// assumes the decode stage offers one slot a cycle on the core clock,
// honours squash, busy and redirect, and holds no slot while busy
`timescale 1ns/1ps
module cer_top
#(
  parameter logic [15:0] RESERVED_MAJOR = 16'h0000
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire cer_pkg::cer_slot_s slot,
  input wire logic peripheral_irq,
  input wire logic system_break_irq_n,
  input wire logic flash_reprogram,
  input wire logic psw_wr,
  input wire cer_pkg::cer_psw_s psw_wr_data,
  input wire logic bpc_wr,
  input wire logic [31:0] bpc_wr_data,
  input wire logic carry_wr,
  input wire logic carry_in,
  output logic redirect,
  output logic [31:0] redirect_addr,
  output logic squash,
  output logic mem_inhibit,
  output logic busy,
  output cer_pkg::cer_psw_s processor_status_word,
  output logic [31:0] backup_program_counter,
  output cer_pkg::cer_cause_e cause,
  output logic undefined_opcode_fault,
  output logic misaligned_access_fault,
  output logic periph_ack,
  output logic sys_break_ack
);

////////////////////////////////////////////////////////////////////////////////
// declarations

cer_pkg::cer_state_e state;
cer_pkg::cer_state_e next_state;
cer_pkg::cer_cause_e next_cause;
logic [31:0] vec_q;
logic [31:0] next_vec;
logic [31:0] capt_q;
logic [31:0] next_capt;
logic [1:0] boot_cnt;
logic sbi_meta;
logic sbi_sync;
logic sbi_prev;
logic sbi_pending;
logic flash_meta;
logic flash_sync;
logic take_slot;
logic undef_hit;
logic misalign_hit;
logic word_break;
logic sbi_take;
logic periph_take;
logic trap_take;
logic return_take;
logic entry_take;
logic sbi_fall;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

always_ff @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    sbi_meta <= 1'h1;
    sbi_sync <= 1'h1;
    sbi_prev <= 1'h1;
    flash_meta <= 1'h0;
    flash_sync <= 1'h0;
  end
  else
  begin
    sbi_meta <= system_break_irq_n;
    sbi_sync <= sbi_meta;
    sbi_prev <= sbi_sync;
    flash_meta <= flash_reprogram;
    flash_sync <= flash_meta;
  end
end

assign sbi_fall = sbi_prev & ~sbi_sync;
// a new falling edge wins over the clear of the same cycle
always_ff @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    sbi_pending <= 1'h0;
  end
  else if (sbi_fall)
  begin
    sbi_pending <= 1'h1;
  end
  else if (sbi_take)
  begin
    sbi_pending <= 1'h0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// detection and priority

function automatic logic misaligned(input cer_pkg::cer_mem_e kind,
                                    input logic [1:0] low);
  logic hit;
  hit = 1'h0;
  unique case (kind)
    cer_pkg::CER_MEM_HALF_S,
    cer_pkg::CER_MEM_HALF_U,
    cer_pkg::CER_MEM_HALF_W: hit = low[0]; // see RULE21
    cer_pkg::CER_MEM_WORD_R,
    cer_pkg::CER_MEM_WORD_W,
    cer_pkg::CER_MEM_LOCK_R,
    cer_pkg::CER_MEM_UNLOCK_W:
      hit = (low != cer_pkg::WORD_ALIGNED); // see RULE22
    cer_pkg::CER_MEM_NONE: hit = 1'h0;
  endcase
  return hit;
endfunction

assign take_slot = slot.valid & ~busy & (state == cer_pkg::CER_IDLE);
assign undef_hit = take_slot & // see RULE8
  RESERVED_MAJOR[slot.opcode[cer_pkg::MAJOR_MSB:cer_pkg::MAJOR_LSB]];
assign misalign_hit = take_slot & ~undef_hit &
  misaligned(slot.mem_kind, slot.mem_addr_low);
assign word_break = slot.break_point &
  (slot.instr_addr[1:0] == cer_pkg::WORD_ALIGNED);
// faults of the slot come first; the irq line is left pending
assign sbi_take = take_slot & ~undef_hit & ~misalign_hit & word_break &
  sbi_pending; // see RULE26
assign periph_take = take_slot & ~undef_hit & ~misalign_hit & word_break &
  ~sbi_pending & peripheral_irq &
  processor_status_word.interrupt_enable; // see RULE10 see RULE24
assign trap_take = take_slot & ~undef_hit & ~misalign_hit & ~sbi_take &
  ~periph_take & slot.trap;
assign return_take = take_slot & ~undef_hit & ~misalign_hit & ~sbi_take &
  ~periph_take & ~slot.trap & slot.return_from_handler_op;
assign entry_take = undef_hit | misalign_hit | sbi_take | periph_take |
  trap_take;

always_comb
begin
  next_cause = cer_pkg::CER_CAUSE_NONE;
  next_vec = cer_pkg::VEC_POWER_ON;
  next_capt = slot.instr_addr;
  if (undef_hit)
  begin
    next_cause = cer_pkg::CER_CAUSE_UNDEF;
    next_vec = cer_pkg::VEC_UNDEF; // see RULE16
    next_capt = slot.instr_addr; // see RULE13 see RULE14
  end
  else if (misalign_hit)
  begin
    next_cause = cer_pkg::CER_CAUSE_MISALIGN;
    next_vec = cer_pkg::VEC_MISALIGN; // see RULE17
    next_capt = slot.instr_addr; // see RULE13 see RULE14
  end
  else if (sbi_take)
  begin
    next_cause = cer_pkg::CER_CAUSE_SYS_BREAK;
    next_vec = cer_pkg::VEC_SYS_BREAK; // see RULE6
  end
  else if (periph_take)
  begin
    next_cause = cer_pkg::CER_CAUSE_PERIPH;
    next_vec = cer_pkg::VEC_PERIPH; // see RULE6
  end
  else if (trap_take)
  begin
    next_cause = cer_pkg::CER_CAUSE_TRAP;
    next_vec = cer_pkg::VEC_TRAP_BASE |
      {26'h0, slot.trap_num, 2'h0}; // see RULE5
    next_capt = slot.instr_addr + cer_pkg::NEXT_INSTR_STEP;
  end
  else if (return_take)
  begin
    next_vec = {backup_program_counter[31:2],
      cer_pkg::WORD_ALIGNED}; // see RULE1 see RULE15
  end
end

////////////////////////////////////////////////////////////////////////////////
// sequencer

always_comb
begin
  next_state = state;
  unique case (state)
    cer_pkg::CER_IDLE:
    begin
      if (entry_take)
      begin
        next_state = cer_pkg::CER_SAVE;
      end
      else if (return_take)
      begin
        next_state = cer_pkg::CER_VECTOR;
      end
    end
    cer_pkg::CER_SAVE: next_state = cer_pkg::CER_UPDATE; // see RULE25
    cer_pkg::CER_UPDATE: next_state = cer_pkg::CER_CAPTURE;
    cer_pkg::CER_CAPTURE: next_state = cer_pkg::CER_VECTOR;
    cer_pkg::CER_VECTOR: next_state = cer_pkg::CER_IDLE;
    cer_pkg::CER_BOOT:
    begin
      if (boot_cnt == cer_pkg::BOOT_WAIT)
      begin
        next_state = cer_pkg::CER_VECTOR;
      end
    end
    default: next_state = cer_pkg::CER_IDLE;
  endcase
end

// the boot count lets the flash pin settle through its synchroniser
always_ff @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    state <= cer_pkg::CER_BOOT;
    boot_cnt <= 2'h0;
  end
  else
  begin
    state <= next_state;
    if (state == cer_pkg::CER_BOOT)
    begin
      boot_cnt <= boot_cnt + 2'h1;
    end
  end
end

always_ff @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    cause <= cer_pkg::CER_CAUSE_POWER_ON;
    vec_q <= cer_pkg::VEC_POWER_ON;
    capt_q <= 32'h0;
  end
  else if (state == cer_pkg::CER_BOOT)
  begin
    vec_q <= flash_sync ? cer_pkg::VEC_POWER_ON_FLASH
                        : cer_pkg::VEC_POWER_ON; // see RULE4 see RULE7
  end
  else if (entry_take)
  begin
    cause <= next_cause;
    vec_q <= next_vec;
    capt_q <= next_capt;
  end
  else if (return_take)
  begin
    vec_q <= next_vec;
  end
end

////////////////////////////////////////////////////////////////////////////////
// pipeline handshake outputs

always_ff @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    busy <= 1'h1;
  end
  else if (entry_take | return_take)
  begin
    busy <= 1'h1;
  end
  else if (state == cer_pkg::CER_IDLE)
  begin
    busy <= 1'h0;
  end
end

// the vector entry holds the jump the core then fetches
always_ff @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    redirect <= 1'h0;
    redirect_addr <= cer_pkg::VEC_POWER_ON;
  end
  else if (state == cer_pkg::CER_VECTOR)
  begin
    redirect <= 1'h1; // see RULE18
    redirect_addr <= vec_q;
  end
  else
  begin
    redirect <= 1'h0;
  end
end

// squash kills the slot and everything younger
always_ff @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    squash <= 1'h0;
    mem_inhibit <= 1'h0;
    undefined_opcode_fault <= 1'h0;
    misaligned_access_fault <= 1'h0;
    periph_ack <= 1'h0;
    sys_break_ack <= 1'h0;
  end
  else
  begin
    squash <= entry_take; // see RULE9 see RULE26
    mem_inhibit <= undef_hit | misalign_hit; // see RULE23
    undefined_opcode_fault <= undef_hit;
    misaligned_access_fault <= misalign_hit;
    periph_ack <= periph_take;
    sys_break_ack <= sbi_take;
  end
end

////////////////////////////////////////////////////////////////////////////////
// status word

always_ff @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    processor_status_word <= '0;
  end
  else if (state == cer_pkg::CER_SAVE)
  begin
    processor_status_word.saved_stack_mode <=
      processor_status_word.stack_mode_select; // see RULE11
    processor_status_word.saved_interrupt_enable <=
      processor_status_word.interrupt_enable;
    processor_status_word.saved_arith_out_flag <=
      processor_status_word.carry_flag;
  end
  else if (state == cer_pkg::CER_UPDATE)
  begin
    if (cause == cer_pkg::CER_CAUSE_SYS_BREAK ||
        cause == cer_pkg::CER_CAUSE_PERIPH)
    begin
      processor_status_word.stack_mode_select <=
        cer_pkg::RESET_FLAG; // see RULE6
    end
    processor_status_word.interrupt_enable <=
      cer_pkg::RESET_FLAG; // see RULE12
    processor_status_word.carry_flag <= cer_pkg::RESET_FLAG;
  end
  else if (return_take)
  begin
    // saved bits are left as they are; software must not trust them
    processor_status_word.stack_mode_select <=
      processor_status_word.saved_stack_mode; // see RULE2 see RULE3
    processor_status_word.interrupt_enable <=
      processor_status_word.saved_interrupt_enable;
    processor_status_word.carry_flag <=
      processor_status_word.saved_arith_out_flag;
  end
  else if (psw_wr && state == cer_pkg::CER_IDLE && !busy)
  begin
    processor_status_word <= psw_wr_data;
  end
  else if (carry_wr && state == cer_pkg::CER_IDLE && !busy)
  begin
    processor_status_word.carry_flag <= carry_in;
  end
end

////////////////////////////////////////////////////////////////////////////////
// backup program counter

always_ff @(posedge clk or negedge rstn)
begin
  if (!rstn)
  begin
    backup_program_counter <= 32'h0;
  end
  else if (state == cer_pkg::CER_CAPTURE)
  begin
    backup_program_counter <= capt_q; // see RULE13 see RULE14
  end
  else if (bpc_wr && state == cer_pkg::CER_IDLE && !busy)
  begin
    backup_program_counter <= bpc_wr_data;
  end
end

endmodule // cer_top

// ===== test/cer_assertions.sv
// cer_assertions: timing checks on the exception sequencer ports
// assumes a bind into cer_top with the same reserved-major parameter
`timescale 1ns/1ps
module cer_assertions
#(
  parameter logic [15:0] RESERVED_MAJOR = 16'h0000
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire cer_pkg::cer_slot_s slot,
  input wire logic peripheral_irq,
  input wire logic redirect,
  input wire logic [31:0] redirect_addr,
  input wire logic squash,
  input wire logic mem_inhibit,
  input wire logic busy,
  input wire cer_pkg::cer_psw_s processor_status_word,
  input wire logic [31:0] backup_program_counter,
  input wire logic undefined_opcode_fault,
  input wire logic misaligned_access_fault,
  input wire logic periph_ack,
  input wire cer_pkg::cer_cause_e cause,
  input wire logic sys_break_ack
);
  cer_pkg::cer_psw_s st;
  logic take;
  logic undef;
  logic mis;
  logic rtn;
  assign st = processor_status_word;
  assign take = slot.valid && !busy;
  assign undef = RESERVED_MAJOR[slot.opcode[15:12]];
  assign mis = (slot.mem_kind == cer_pkg::CER_MEM_NONE) ? 1'b0 :
    (slot.mem_kind < cer_pkg::CER_MEM_WORD_R) ? slot.mem_addr_low[0] :
    (slot.mem_addr_low != 2'h0);
  assign rtn = take && slot.return_from_handler_op && !slot.trap &&
    !slot.break_point && !undef && slot.mem_kind == cer_pkg::CER_MEM_NONE;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_fault_take;
    take && (undef || mis);
  endsequence
  sequence s_saved;
    st.saved_stack_mode == $past(st.stack_mode_select, 1) &&
    st.saved_interrupt_enable == $past(st.interrupt_enable, 1) &&
    st.saved_arith_out_flag == $past(st.carry_flag, 1);
  endsequence
  sequence s_cleared;
    !st.interrupt_enable && !st.carry_flag &&
    st.stack_mode_select == $past(st.stack_mode_select, 2);
  endsequence

  a_undef_raise: assert property (take && undef |=>
    undefined_opcode_fault && squash && mem_inhibit && !periph_ack &&
    cause == cer_pkg::CER_CAUSE_UNDEF)
    else $error("undefined opcode not faulted");
  a_undef_vector: assert property (take && undef |-> ##5
    redirect && redirect_addr == cer_pkg::VEC_UNDEF)
    else $error("undefined opcode vector wrong");
  a_misalign_raise: assert property (take && !undef && mis |=>
    misaligned_access_fault && mem_inhibit &&
    cause == cer_pkg::CER_CAUSE_MISALIGN ##4
    redirect && redirect_addr == cer_pkg::VEC_MISALIGN)
    else $error("misaligned access not handled");
  a_fault_flags: assert property (s_fault_take |->
    ##2 s_saved ##1 s_cleared)
    else $error("fault entry flags wrong");
  a_fault_bpc: assert property (s_fault_take |-> ##4
    backup_program_counter == $past(slot.instr_addr, 4) ##1 redirect)
    else $error("fault backup counter wrong");
  a_return_pc: assert property (rtn |-> ##2 redirect &&
    redirect_addr == {$past(backup_program_counter[31:2], 2), 2'b00})
    else $error("return target wrong");
  a_return_flags: assert property (rtn |=>
    st.stack_mode_select == $past(st.saved_stack_mode) &&
    st.interrupt_enable == $past(st.saved_interrupt_enable) &&
    st.carry_flag == $past(st.saved_arith_out_flag))
    else $error("return flags wrong");
  a_periph_gate: assert property (periph_ack |->
    $past(st.interrupt_enable && slot.break_point && peripheral_irq &&
    slot.instr_addr[1:0] == 2'h0))
    else $error("peripheral taken without enable");
  a_periph_vector: assert property (periph_ack |-> ##4 redirect &&
    redirect_addr == cer_pkg::VEC_PERIPH && !st.stack_mode_select &&
    cause == cer_pkg::CER_CAUSE_PERIPH)
    else $error("peripheral vector wrong");
  a_break_vector: assert property (sys_break_ack |->
    cause == cer_pkg::CER_CAUSE_SYS_BREAK ##4 redirect &&
    redirect_addr == cer_pkg::VEC_SYS_BREAK && !st.stack_mode_select &&
    !st.interrupt_enable)
    else $error("system break vector wrong");
endmodule // cer_assertions

bind cer_top cer_assertions #(.RESERVED_MAJOR(RESERVED_MAJOR))
  cer_assertions_inst (.*);

// ===== test/cer_pipe_model.sv
// cer_pipe_model: decode stage that offers one slot to the sequencer
// assumes the bench raises offer only while busy is low
`timescale 1ns/1ps
module cer_pipe_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic offer,
  input wire cer_pkg::cer_slot_s req,
  input wire logic busy,
  output cer_pkg::cer_slot_s slot
);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      slot <= '0;
    else if (offer)
      slot <= req;
    else if (slot.valid && !busy)
      // taken: released fields show the inverse, not stale values
      slot <= {1'b0, ~slot[$bits(slot)-2:0]};
  end
endmodule // cer_pipe_model

// ===== test/cer_top_bench.sv
// cer_top_bench: self-checking bench for the exception sequencer
// assumes a 25 MHz core clock and the pipe model as slot source
`timescale 1ns/1ps
module cer_top_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic offer = 1'b0;
  cer_pkg::cer_slot_s req = '0;
  cer_pkg::cer_slot_s slot;
  logic peripheral_irq = 1'b0;
  logic system_break_irq_n = 1'b1;
  logic flash_reprogram = 1'b0;
  logic psw_wr = 1'b0;
  cer_pkg::cer_psw_s psw_wr_data = '0;
  logic bpc_wr = 1'b0;
  logic [31:0] bpc_wr_data = '0;
  logic redirect;
  logic busy;
  logic [31:0] redirect_addr;
  logic [31:0] backup_program_counter;
  cer_pkg::cer_psw_s processor_status_word;
  int errors = 0;
  int compares = 0;
  logic [31:0] lf = 32'h5f9f31f4;
  logic [31:0] a;
  logic [31:0] b;
  cer_pkg::cer_psw_s p;

  always #20 clk = ~clk;

  cer_top #(.RESERVED_MAJOR(16'h8000)) cer_top_inst (.*, .carry_wr(1'b0),
    .carry_in(1'b0), .squash(), .mem_inhibit(), .cause(), .periph_ack(),
    .undefined_opcode_fault(), .misaligned_access_fault(),
    .sys_break_ack());
  cer_pipe_model cer_pipe_model_inst (.*);

  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction

  function automatic cer_pkg::cer_slot_s mk(input logic [31:0] ad);
    mk = '0;
    mk.valid = 1'b1;
    mk.instr_addr = ad;
    mk.opcode = {1'b0, lf[14:0]};
  endfunction

  task automatic fresh();
    b = rnd();
    p = b[5:0];
    a = rnd();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_redir(input int lim);
    int n;
    n = 0;
    @(posedge clk);
    while (redirect !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic boot(input logic fr);
    rstn <= 1'b0;
    flash_reprogram <= fr;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    wait_redir(20);
    chk(redirect, 1'b1);
    chk(redirect_addr, fr ? 32'h0080_1000 : 32'h0000_0000);
    @(posedge clk);
  endtask

  task automatic run(input cer_pkg::cer_slot_s s, input logic en,
    input logic [31:0] vec, input logic [31:0] bpc_e, input logic smc);
    psw_wr <= 1'b1;
    psw_wr_data <= p;
    bpc_wr <= 1'b1;
    bpc_wr_data <= b;
    @(posedge clk);
    psw_wr <= 1'b0;
    bpc_wr <= 1'b0;
    offer <= 1'b1;
    req <= s;
    @(posedge clk);
    offer <= 1'b0;
    wait_redir(8);
    chk(redirect, en);
    if (en && s.return_from_handler_op)
      chk(processor_status_word[2:0], p[5:3]);
    else if (en)
    begin
      chk(backup_program_counter, bpc_e);
      chk(processor_status_word, {p[2:0], p[2] & !smc, 2'b00});
    end
    if (en)
      chk(redirect_addr, vec);
    @(posedge clk);
  endtask

  initial
  begin
    cer_pkg::cer_slot_s s;
    int k;
    int n;
    boot(1'b1);
    boot(1'b0);
    $display("test boot done");
    for (k = 0; k < 2; k++)
    begin
      fresh();
      p.interrupt_enable = 1'b1;
      peripheral_irq <= (k == 0);
      s = mk({a[31:2], k[0], 1'b0});
      s.opcode[15:12] = 4'hf;
      s.break_point = 1'b1;
      run(s, 1'b1, 32'h20, s.instr_addr, 1'b0);
    end
    peripheral_irq <= 1'b1;
    for (k = 0; k < 3; k++)
    begin
      fresh();
      p.interrupt_enable = (k != 1);
      s = mk({a[31:2], k == 2, 1'b0});
      s.break_point = 1'b1;
      run(s, k == 0, 32'h80, s.instr_addr, 1'b1);
    end
    peripheral_irq <= 1'b0;
    fresh();
    p.interrupt_enable = 1'b0;
    system_break_irq_n <= 1'b0;
    repeat (4) @(posedge clk);
    system_break_irq_n <= 1'b1;
    s = mk({a[31:2], 2'b00});
    s.break_point = 1'b1;
    run(s, 1'b1, 32'h10, s.instr_addr, 1'b1);
    $display("test interrupts done");
    for (k = 1; k < 8; k++)
      for (n = 0; n < 4; n++)
      begin
        fresh();
        s = mk({a[31:2], 2'b00});
        s.mem_kind = cer_pkg::cer_mem_e'(k);
        s.mem_addr_low = n[1:0];
        run(s, k < 4 ? n[0] : n != 0, 32'h30, s.instr_addr, 1'b0);
      end
    $display("test misaligned done");
    for (k = 0; k < 16; k++)
    begin
      fresh();
      s = mk({a[31:2], k[0], 1'b0});
      s.trap = 1'b1;
      s.trap_num = k[3:0];
      run(s, 1'b1, 32'h40 + 32'(4 * k), s.instr_addr + 32'h4, 1'b0);
    end
    $display("test traps done");
    fresh();
    b[1:0] = 2'b10;
    s = mk(a);
    s.return_from_handler_op = 1'b1;
    run(s, 1'b1, {b[31:2], 2'b00}, b, 1'b0);
    $display("test return done");
    final_report();
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule // cer_top_bench
